// File: logic/vdi_crc6.v
`timescale 1ns/1ps

// -----------------------------------------------------------------
// crc over the low payload bits, c0 shifted in first
// -----------------------------------------------------------------
`include "vdi_defines.vh"

module vdi_crc6 (
  input  wire        mclk,
  input  wire        rst,
  input  wire [13:0] data,
  output reg  [5:0]  crc
);

  reg [5:0] next_crc;
  reg       fb;
  integer   i;

  always @* begin
    next_crc = `VDI_CRC_PRESET;
    fb       = 1'b0;
    for (i = 0; i < `VDI_CRC_DATA_BITS; i = i + 1) begin
      fb       = next_crc[5] ^ data[i];
      next_crc = {next_crc[4:0], 1'b0} ^ (fb ? `VDI_CRC_POLY_LOW : 6'h00);
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      crc <= `VDI_CRC_PRESET;
    end else begin
      crc <= next_crc;
    end
  end

endmodule // vdi_crc6

// File: logic/vdi_defines.vh
`ifndef VDI_DEFINES_VH
`define VDI_DEFINES_VH

// -----------------------------------------------------------------
// register subaddresses
// -----------------------------------------------------------------
`define VDI_ADDR_CC_EVEN_LO   5'h0e
`define VDI_ADDR_CC_EVEN_HI   5'h0f
`define VDI_ADDR_CC_ODD_LO    5'h10
`define VDI_ADDR_CC_ODD_HI    5'h11
`define VDI_ADDR_LINE_CTRL_0  5'h12
`define VDI_ADDR_LINE_CTRL_1  5'h13
`define VDI_ADDR_LINE_CTRL_2  5'h14
`define VDI_ADDR_LINE_CTRL_3  5'h15
`define VDI_ADDR_CM_CTRL      5'h16
`define VDI_ADDR_CM_MID       5'h17
`define VDI_ADDR_CM_LOW       5'h18
`define VDI_ADDR_TTX_TIMING   5'h19

`define VDI_REG_RESET         8'h00
`define VDI_READ_UNMAPPED     8'h00

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define VDI_CM_WSS_EN_BIT     7
`define VDI_CM_EVEN_EN_BIT    6
`define VDI_CM_ODD_EN_BIT     5
`define VDI_CM_CRC_AUTO_BIT   4
`define VDI_CM_TAIL_MSB       3
`define VDI_CM_SHARED_MSB     5
`define VDI_TTX_RISE_MSB      7
`define VDI_TTX_RISE_LSB      4
`define VDI_TTX_FALL_MSB      3
`define VDI_TTX_FALL_LSB      0
`define VDI_PARITY_BIT        7

// -----------------------------------------------------------------
// line numbers (mask bases field relative; caption and copy lines frame numbered, even field frame number = line + offset)
// -----------------------------------------------------------------
`define VDI_PED_FIRST_LINE    10'd10
`define VDI_TTX_FIRST_LINE    10'd7
`define VDI_MASK_LINES        10'd16
`define VDI_CC_LINE_ODD       10'd21
`define VDI_CC_LINE_EVEN      10'd284
`define VDI_CM_LINE_ODD       10'd20
`define VDI_CM_LINE_EVEN      10'd283
`define VDI_NTSC_EVEN_OFS     10'd263

// -----------------------------------------------------------------
// copy-management crc and timing
// -----------------------------------------------------------------
`define VDI_CRC_PRESET        6'h3f
`define VDI_CRC_POLY_LOW      6'h03
`define VDI_CRC_DATA_BITS     14
`define VDI_CLK_MHZ           20
`define VDI_TTX_WIN_NS        51892
`define VDI_TTX_CNT_W         12

`endif

// File: logic/vdi_regs.v
`timescale 1ns/1ps

`include "vdi_defines.vh"

// What this block does
// - even-field extended caption bytes held at subaddresses 0x0e and 0x0f.
// - odd-field caption bytes held at subaddresses 0x10 and 0x11.
// - four per-line control registers at 0x12..0x15, one bit per line.
// - in NTSC a set line bit turns the pedestal off on that line.
// - in PAL a set line bit turns teletext on for that line.
// - pedestal mask bits 0..15 map to lines 10..25, one mask per field (odd 0x12/0x13, even 0x14/0x15).
// - teletext mask bits 0..15 map to lines 7..22, one mask per field (odd 0x12/0x13, even 0x14/0x15).
// - bits 7:4 at 0x19 delay the request rising edge 0..15 clocks.
// - bits 3:0 at 0x19 pull the falling edge in, shrinking the window.
// - with fall field zero, the falling edge follows the rising edge shift.
// - bits 3:0 at 0x16 are the last four copy-management bits only.
// - crc-select 1 computes the last six bits; 0 sends register bits.
// - odd-field enable inserts copy-management on odd fields, NTSC only.
// - even-field enable inserts copy-management on even fields, NTSC only.
// - bit 7 at 0x16 enables widescreen signalling, PAL only.
// - 0x17 bits 5:0 and 0x18 are copy data in NTSC, widescreen in PAL.
// - 0x17 bits 7:6 are copy-management payload only, unused in PAL.
// - caption bytes are seven data bits plus odd parity, after a start bit.
// - odd captions on line 21, even on 284; pixels ignored there.
// - crc is x^6+x+1 preset to ones over the low fourteen bits.
// - copy-management goes on line 20 odd and 283 even, after a reference pulse.
module vdi_regs (
  input  wire        mclk,
  input  wire        rst,
  input  wire [4:0]  subaddress_bits,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output wire        reg_hit,
  input  wire        std_pal,
  input  wire        field_even,
  input  wire        line_start,
  input  wire [9:0]  field_line,
  input  wire        ttx_win_start,
  output reg         pedestal_off,
  output reg         ttx_line_en,
  output reg         teletext_request_out,
  output reg         cc_line,
  output reg         pixel_ignore,
  output reg  [16:0] cc_word,
  output reg         cm_line,
  output reg  [20:0] cm_word,
  output reg         wss_en,
  output reg  [13:0] wss_data
);

  // -----------------------------------------------------------------
  // timing constants
  // -----------------------------------------------------------------
  // window length in clocks; the cut to the counter width is deliberate
  localparam integer TTX_WIN_NUM = (`VDI_TTX_WIN_NS * `VDI_CLK_MHZ) / 1000;
  localparam [`VDI_TTX_CNT_W-1:0] TTX_WIN_CYC = TTX_WIN_NUM[`VDI_TTX_CNT_W-1:0];
  localparam [`VDI_TTX_CNT_W-1:0] TTX_CNT_MAX = {`VDI_TTX_CNT_W{1'b1}};

  // -----------------------------------------------------------------
  // register storage
  // -----------------------------------------------------------------
  reg  [7:0] cc_even_data_lo;
  reg  [7:0] cc_even_data_hi;
  reg  [7:0] cc_odd_data_lo;
  reg  [7:0] cc_odd_data_hi;
  reg  [7:0] vbi_line_ctrl_0;
  reg  [7:0] vbi_line_ctrl_1;
  reg  [7:0] vbi_line_ctrl_2;
  reg  [7:0] vbi_line_ctrl_3;
  reg  [7:0] copy_mgmt_ctrl;
  reg  [7:0] copy_mgmt_payload_mid;
  reg  [7:0] copy_mgmt_payload_low;
  reg  [7:0] teletext_request_timing;

  wire [15:0] odd_line_mask;
  wire [15:0] even_line_mask;
  wire [3:0]  request_rise_offset;
  wire [3:0]  request_fall_offset;
  wire        crc_auto_select;
  wire        copy_mgmt_odd_enable;
  wire        copy_mgmt_even_enable;
  wire        widescreen_enable;
  wire [5:0]  crc_value;
  wire [13:0] cm_low_bits;
  wire [19:0] next_cm_payload;
  wire [9:0]  frame_line;
  wire        is_cc_line;
  wire        is_cm_line;
  wire        next_ped_off;
  wire        next_ttx_en;

  reg         line_start_d;
  reg         cm_pending;
  reg  [19:0] cm_snap;
  reg         cm_crc_snap;
  reg  [`VDI_TTX_CNT_W-1:0] ttx_cnt;
  reg         ttx_run;
  reg  [`VDI_TTX_CNT_W-1:0] fall_pos;
  reg         next_request;
  reg  [7:0]  next_rdata;
  reg         hit;

  // same mask layout serves pedestal (NTSC) and teletext (PAL)
  assign odd_line_mask         = {vbi_line_ctrl_1, vbi_line_ctrl_0};
  assign even_line_mask        = {vbi_line_ctrl_3, vbi_line_ctrl_2};
  assign request_rise_offset   = teletext_request_timing[`VDI_TTX_RISE_MSB:`VDI_TTX_RISE_LSB];
  assign request_fall_offset   = teletext_request_timing[`VDI_TTX_FALL_MSB:`VDI_TTX_FALL_LSB];
  assign crc_auto_select       = copy_mgmt_ctrl[`VDI_CM_CRC_AUTO_BIT];
  assign copy_mgmt_odd_enable  = copy_mgmt_ctrl[`VDI_CM_ODD_EN_BIT];
  assign copy_mgmt_even_enable = copy_mgmt_ctrl[`VDI_CM_EVEN_EN_BIT];
  assign widescreen_enable     = copy_mgmt_ctrl[`VDI_CM_WSS_EN_BIT];

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function mask_bit;
    input [15:0] mask;
    input [9:0]  line;
    input [9:0]  first;
    reg   [9:0]  idx;
    begin
      idx = line - first;
      if (line >= first && idx < `VDI_MASK_LINES) begin
        mask_bit = mask[idx[3:0]];
      end else begin
        mask_bit = 1'b0;
      end
    end
  endfunction

  // seven data bits then an odd parity bit in the top position
  function [7:0] cc_byte;
    input [7:0] raw;
    begin
      cc_byte = {~(^raw[6:0]), raw[6:0]};
    end
  endfunction

  // -----------------------------------------------------------------
  // register write and read
  // -----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      cc_even_data_lo         <= `VDI_REG_RESET;
      cc_even_data_hi         <= `VDI_REG_RESET;
      cc_odd_data_lo          <= `VDI_REG_RESET;
      cc_odd_data_hi          <= `VDI_REG_RESET;
      vbi_line_ctrl_0         <= `VDI_REG_RESET;
      vbi_line_ctrl_1         <= `VDI_REG_RESET;
      vbi_line_ctrl_2         <= `VDI_REG_RESET;
      vbi_line_ctrl_3         <= `VDI_REG_RESET;
      copy_mgmt_ctrl          <= `VDI_REG_RESET;
      copy_mgmt_payload_mid   <= `VDI_REG_RESET;
      copy_mgmt_payload_low   <= `VDI_REG_RESET;
      teletext_request_timing <= `VDI_REG_RESET;
    end else if (reg_wr) begin
      case (subaddress_bits)
        `VDI_ADDR_CC_EVEN_LO:  cc_even_data_lo         <= reg_wdata;
        `VDI_ADDR_CC_EVEN_HI:  cc_even_data_hi         <= reg_wdata;
        `VDI_ADDR_CC_ODD_LO:   cc_odd_data_lo          <= reg_wdata;
        `VDI_ADDR_CC_ODD_HI:   cc_odd_data_hi          <= reg_wdata;
        `VDI_ADDR_LINE_CTRL_0: vbi_line_ctrl_0         <= reg_wdata;
        `VDI_ADDR_LINE_CTRL_1: vbi_line_ctrl_1         <= reg_wdata;
        `VDI_ADDR_LINE_CTRL_2: vbi_line_ctrl_2         <= reg_wdata;
        `VDI_ADDR_LINE_CTRL_3: vbi_line_ctrl_3         <= reg_wdata;
        `VDI_ADDR_CM_CTRL:     copy_mgmt_ctrl          <= reg_wdata;
        `VDI_ADDR_CM_MID:      copy_mgmt_payload_mid   <= reg_wdata;
        `VDI_ADDR_CM_LOW:      copy_mgmt_payload_low   <= reg_wdata;
        `VDI_ADDR_TTX_TIMING:  teletext_request_timing <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  always @* begin
    hit        = 1'b1;
    next_rdata = `VDI_READ_UNMAPPED;
    case (subaddress_bits)
      `VDI_ADDR_CC_EVEN_LO:  next_rdata = cc_even_data_lo;
      `VDI_ADDR_CC_EVEN_HI:  next_rdata = cc_even_data_hi;
      `VDI_ADDR_CC_ODD_LO:   next_rdata = cc_odd_data_lo;
      `VDI_ADDR_CC_ODD_HI:   next_rdata = cc_odd_data_hi;
      `VDI_ADDR_LINE_CTRL_0: next_rdata = vbi_line_ctrl_0;
      `VDI_ADDR_LINE_CTRL_1: next_rdata = vbi_line_ctrl_1;
      `VDI_ADDR_LINE_CTRL_2: next_rdata = vbi_line_ctrl_2;
      `VDI_ADDR_LINE_CTRL_3: next_rdata = vbi_line_ctrl_3;
      `VDI_ADDR_CM_CTRL:     next_rdata = copy_mgmt_ctrl;
      `VDI_ADDR_CM_MID:      next_rdata = copy_mgmt_payload_mid;
      `VDI_ADDR_CM_LOW:      next_rdata = copy_mgmt_payload_low;
      `VDI_ADDR_TTX_TIMING:  next_rdata = teletext_request_timing;
      default:               hit        = 1'b0;
    endcase
  end

  // other subaddresses belong to neighbouring register banks
  assign reg_hit = hit;

  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= `VDI_READ_UNMAPPED;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // -----------------------------------------------------------------
  // per-line pedestal and teletext enables
  // -----------------------------------------------------------------
  assign next_ped_off = !std_pal &&
    mask_bit(field_even ? even_line_mask : odd_line_mask,
             field_line, `VDI_PED_FIRST_LINE);
  assign next_ttx_en  = std_pal &&
    mask_bit(field_even ? even_line_mask : odd_line_mask,
             field_line, `VDI_TTX_FIRST_LINE);

  always @(posedge mclk) begin
    if (rst) begin
      pedestal_off <= 1'b0;
      ttx_line_en  <= 1'b0;
    end else begin
      pedestal_off <= next_ped_off;
      ttx_line_en  <= next_ttx_en;
    end
  end

  // -----------------------------------------------------------------
  // teletext request pulse
  // -----------------------------------------------------------------
  // a zero fall field keeps the width fixed; otherwise the fall is pulled in
  always @* begin
    if (request_fall_offset == 4'h0) begin
      fall_pos = {{(`VDI_TTX_CNT_W-4){1'b0}}, request_rise_offset} + TTX_WIN_CYC;
    end else begin
      fall_pos = TTX_WIN_CYC - {{(`VDI_TTX_CNT_W-4){1'b0}}, request_fall_offset};
    end
    next_request = ttx_run && ttx_line_en &&
      (ttx_cnt >= {{(`VDI_TTX_CNT_W-4){1'b0}}, request_rise_offset}) &&
      (ttx_cnt < fall_pos);
  end

  always @(posedge mclk) begin
    if (rst) begin
      ttx_cnt              <= {`VDI_TTX_CNT_W{1'b0}};
      ttx_run              <= 1'b0;
      teletext_request_out <= 1'b0;
    end else begin
      if (ttx_win_start && ttx_line_en) begin
        ttx_cnt <= {`VDI_TTX_CNT_W{1'b0}};
        ttx_run <= 1'b1;
      end else if (ttx_run) begin
        if (ttx_cnt == TTX_CNT_MAX || line_start) begin
          ttx_run <= 1'b0;
        end
        ttx_cnt <= ttx_cnt + 1'b1;
      end
      teletext_request_out <= next_request;
    end
  end

  // -----------------------------------------------------------------
  // closed caption capture
  // -----------------------------------------------------------------
  assign frame_line = field_even ? (field_line + `VDI_NTSC_EVEN_OFS) : field_line;
  assign is_cc_line = !std_pal && (field_even ? (frame_line == `VDI_CC_LINE_EVEN)
                                              : (frame_line == `VDI_CC_LINE_ODD));

  // the word is frozen at line start so a late host write waits a field
  always @(posedge mclk) begin
    if (rst) begin
      cc_line      <= 1'b0;
      pixel_ignore <= 1'b0;
      cc_word      <= 17'h00000;
    end else if (line_start) begin
      cc_line      <= is_cc_line;
      pixel_ignore <= is_cc_line;
      if (is_cc_line) begin
        if (field_even) begin
          cc_word <= {cc_byte(cc_even_data_hi), cc_byte(cc_even_data_lo), 1'b1};
        end else begin
          cc_word <= {cc_byte(cc_odd_data_hi), cc_byte(cc_odd_data_lo), 1'b1};
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // copy-management and widescreen payload
  // -----------------------------------------------------------------
  assign cm_low_bits = {copy_mgmt_payload_mid[`VDI_CM_SHARED_MSB:0],
                        copy_mgmt_payload_low};

  vdi_crc6 u_crc (
    .mclk (mclk),
    .rst  (rst),
    .data (cm_low_bits),
    .crc  (crc_value)
  );

  // c19..c16 from 0x16, c15..c8 from 0x17, c7..c0 from 0x18
  // snapshot and crc both see the registers as they stood at line start
  assign next_cm_payload = cm_crc_snap ?
    {crc_value, cm_snap[`VDI_CRC_DATA_BITS-1:0]} :
    cm_snap;

  assign is_cm_line = !std_pal &&
    (field_even ? (copy_mgmt_even_enable && frame_line == `VDI_CM_LINE_EVEN)
                : (copy_mgmt_odd_enable && frame_line == `VDI_CM_LINE_ODD));

  // capture one clock after line start so the registered crc has settled
  always @(posedge mclk) begin
    if (rst) begin
      line_start_d <= 1'b0;
      cm_pending   <= 1'b0;
      cm_snap      <= 20'h00000;
      cm_crc_snap  <= 1'b0;
      cm_line      <= 1'b0;
      cm_word      <= 21'h000000;
      wss_en       <= 1'b0;
      wss_data     <= 14'h0000;
    end else begin
      line_start_d <= line_start;
      if (line_start) begin
        cm_pending <= is_cm_line;
        cm_line    <= 1'b0;
        cm_snap    <= {copy_mgmt_ctrl[`VDI_CM_TAIL_MSB:0],
                       copy_mgmt_payload_mid[7:6],
                       cm_low_bits};
        cm_crc_snap <= crc_auto_select;
      end else if (line_start_d) begin
        cm_line <= cm_pending;
        if (cm_pending) begin
          cm_word <= {next_cm_payload, 1'b1};
        end
      end
      wss_en <= std_pal && widescreen_enable;
      if (line_start) begin
        wss_data <= cm_low_bits;
      end
    end
  end

endmodule // vdi_regs

// File: verif/vdi_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host side of the register port
// ----------------------------------------------------------------
module vdi_host (
  input  wire       mclk,
  input  wire [7:0] reg_rdata,
  output reg  [4:0] subaddress_bits,
  output reg        reg_wr,
  output reg  [7:0] reg_wdata
);
  initial begin
    subaddress_bits = 5'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  task wr(input [4:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      subaddress_bits <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      // data is not held past the strobe, so a late sample would show
      reg_wdata <= ~d;
    end
  endtask

  task rd(input [4:0] a, output [7:0] d);
    begin
      @(posedge mclk);
      subaddress_bits <= a;
      repeat (2) @(posedge mclk);
      #1;
      d = reg_rdata;
    end
  endtask
endmodule // vdi_host

// File: verif/vdi_regs_chk.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checks on the register block
// ----------------------------------------------------------------
module vdi_regs_chk (
  input wire        mclk,
  input wire        rst,
  input wire [4:0]  subaddress_bits,
  input wire        reg_wr,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  reg_rdata,
  input wire        reg_hit,
  input wire        std_pal,
  input wire        field_even,
  input wire        line_start,
  input wire [9:0]  field_line,
  input wire        ttx_win_start,
  input wire        pedestal_off,
  input wire        ttx_line_en,
  input wire        teletext_request_out,
  input wire        cc_line,
  input wire        pixel_ignore,
  input wire [16:0] cc_word,
  input wire        cm_line,
  input wire [20:0] cm_word,
  input wire        wss_en,
  input wire [13:0] wss_data
);
  reg [10:0] req_len;

  // counts how long the request has been high
  always @(posedge mclk) begin
    if (rst || !teletext_request_out)
      req_len <= 11'h000;
    else
      req_len <= req_len + 11'h001;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  chk_hit_range: assert property (reg_hit == (subaddress_bits >= 5'h0e &&
    subaddress_bits <= 5'h19)) else $error("hit flag wrong for subaddress");
  chk_unmapped_zero: assert property (!reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_ped_ntsc: assert property (pedestal_off |-> !$past(std_pal))
    else $error("pedestal off outside ntsc");
  chk_ttx_pal: assert property (ttx_line_en |-> $past(std_pal))
    else $error("teletext line enable outside pal");
  chk_cc_parity: assert property (cc_line |-> cc_word[0] && ^cc_word[8:1] &&
    ^cc_word[16:9]) else $error("caption start or parity bit wrong");
  chk_cc_line: assert property (line_start && field_line == 10'd21 && !std_pal
    |=> cc_line && pixel_ignore) else $error("caption line not flagged");
  chk_cm_pal: assert property (line_start && std_pal |=> ##1 !cm_line)
    else $error("copy line active in pal");
  chk_cm_ref: assert property (cm_line |-> cm_word[0])
    else $error("copy word lacks reference bit");
  chk_req_width: assert property (teletext_request_out |-> req_len < 11'd1037)
    else $error("teletext request too long");
  chk_wss_pal: assert property (wss_en |-> $past(std_pal))
    else $error("widescreen enabled outside pal");

  cov_cc: cover property ($rose(cc_line));
  cov_cm: cover property ($rose(cm_line));
  cov_req: cover property ($fell(teletext_request_out));
endmodule // vdi_regs_chk

bind vdi_regs vdi_regs_chk vdi_regs_chk_i (
  .mclk(mclk), .rst(rst), .subaddress_bits(subaddress_bits), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .std_pal(std_pal),
  .field_even(field_even), .line_start(line_start), .field_line(field_line),
  .ttx_win_start(ttx_win_start), .pedestal_off(pedestal_off), .ttx_line_en(ttx_line_en),
  .teletext_request_out(teletext_request_out), .cc_line(cc_line),
  .pixel_ignore(pixel_ignore), .cc_word(cc_word), .cm_line(cm_line), .cm_word(cm_word),
  .wss_en(wss_en), .wss_data(wss_data)
);

// File: verif/vdi_regs_tb.sv
`timescale 1ns/1ps
module vdi_regs_tb;
  reg         mclk = 1'b0;
  reg         rst = 1'b1;
  reg         std_pal = 1'b0;
  reg         field_even = 1'b0;
  reg         line_start = 1'b0;
  reg  [9:0]  field_line = 10'h000;
  reg         ttx_win_start = 1'b0;
  wire [4:0]  subaddress_bits;
  wire        reg_wr, reg_hit, pedestal_off, ttx_line_en, teletext_request_out;
  wire        cc_line, pixel_ignore, cm_line, wss_en;
  wire [7:0]  reg_wdata;
  wire [7:0]  reg_rdata;
  wire [16:0] cc_word;
  wire [20:0] cm_word;
  wire [13:0] wss_data;
  integer     fails = 0;
  integer     n_tests = 0;
  integer     i;
  reg  [7:0]  rv;

  always #25 mclk = ~mclk;

  vdi_regs vdi_regs_i (.mclk(mclk), .rst(rst), .subaddress_bits(subaddress_bits),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .std_pal(std_pal), .field_even(field_even), .line_start(line_start),
    .field_line(field_line), .ttx_win_start(ttx_win_start), .pedestal_off(pedestal_off),
    .ttx_line_en(ttx_line_en), .teletext_request_out(teletext_request_out),
    .cc_line(cc_line), .pixel_ignore(pixel_ignore), .cc_word(cc_word), .cm_line(cm_line),
    .cm_word(cm_word), .wss_en(wss_en), .wss_data(wss_data));

  vdi_host vdi_host_i (.mclk(mclk), .reg_rdata(reg_rdata),
    .subaddress_bits(subaddress_bits), .reg_wr(reg_wr), .reg_wdata(reg_wdata));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task chk(input string name, input [20:0] exp, input [20:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task test_done;
    begin
      if (fails == 0 && n_tests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // x^6+x+1 preset to ones, c0 first, crc[0] lands on c14
  function [5:0] crc6(input [13:0] d);
    integer k;
    reg     fb;
    begin
      crc6 = 6'h3f;
      for (k = 0; k < 14; k = k + 1) begin
        fb = d[k] ^ crc6[5];
        crc6 = {crc6[4:0], fb} ^ {4'h0, fb, 1'b0};
      end
    end
  endfunction

  task vline(input pal, input even, input [9:0] ln);
    begin
      @(posedge mclk);
      std_pal <= pal;
      field_even <= even;
      field_line <= ln;
      line_start <= 1'b1;
      @(posedge mclk);
      line_start <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
    end
  endtask

  task lmask(input pal, input even, input [9:0] ln, input ped, input ttx);
    begin
      vline(pal, even, ln);
      chk("line_mask", {ped, ttx}, {pedestal_off, ttx_line_en});
    end
  endtask

  // delay counted from the edge that samples the window start
  task ttx(input [7:0] tim, input [9:0] ln, input integer dly, input integer wid);
    integer n;
    begin
      vdi_host_i.wr(5'h19, tim);
      vline(1'b1, 1'b0, ln);
      @(posedge mclk);
      ttx_win_start <= 1'b1;
      @(posedge mclk);
      ttx_win_start <= 1'b0;
      #1;
      n = 0;
      while (teletext_request_out !== 1'b1 && n < 40) begin
        @(posedge mclk);
        #1;
        n = n + 1;
      end
      chk("req_delay", dly, n);
      n = 0;
      while (teletext_request_out === 1'b1 && n < 1100) begin
        @(posedge mclk);
        #1;
        n = n + 1;
      end
      chk("req_width", wid, n);
    end
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 12; i = i + 1) begin
      vdi_host_i.rd(5'h0e + i[4:0], rv);
      chk("reset_value", 21'h0, rv);
      vdi_host_i.wr(5'h0e + i[4:0], 8'h5a ^ i[7:0]);
      vdi_host_i.rd(5'h0e + i[4:0], rv);
      chk("read_back", 8'h5a ^ i[7:0], rv);
    end
    vdi_host_i.wr(5'h1a, 8'hff);
    vdi_host_i.rd(5'h1a, rv);
    chk("unmapped", 21'h0, {reg_hit, rv});
    vdi_host_i.wr(5'h10, 8'h41);
    vdi_host_i.wr(5'h11, 8'h03);
    vdi_host_i.wr(5'h0e, 8'h07);
    vdi_host_i.wr(5'h0f, 8'h80);
    vline(1'b0, 1'b0, 10'd21);
    chk("cc_odd", {4'hc, 8'h83, 8'hc1, 1'b1}, {cc_line, pixel_ignore, 2'b00, cc_word});
    vline(1'b0, 1'b1, 10'd21);
    chk("cc_even", {4'hc, 8'h80, 8'h07, 1'b1}, {cc_line, pixel_ignore, 2'b00, cc_word});
    vdi_host_i.wr(5'h0f, 8'h01);
    chk("cc_hold", {4'h0, 8'h80, 8'h07, 1'b1}, {4'h0, cc_word});
    vline(1'b1, 1'b0, 10'd21);
    chk("cc_pal", 21'h0, {cc_line, pixel_ignore});
    vdi_host_i.wr(5'h16, 8'h2a);
    vdi_host_i.wr(5'h17, 8'hc5);
    vdi_host_i.wr(5'h18, 8'h3c);
    vline(1'b0, 1'b0, 10'd20);
    chk("cm_odd", {4'ha, 8'hc5, 8'h3c, 1'b1}, cm_word);
    chk("cm_line", 21'h1, cm_line);
    vline(1'b0, 1'b1, 10'd20);
    chk("cm_even_off", 21'h0, cm_line);
    vline(1'b1, 1'b0, 10'd20);
    chk("cm_pal", 21'h0, cm_line);
    vdi_host_i.wr(5'h16, 8'hd5);
    vline(1'b0, 1'b1, 10'd20);
    chk("cm_crc", {crc6(14'h053c), 14'h053c, 1'b1}, cm_word);
    chk("wss_ntsc", 21'h0, wss_en);
    vline(1'b1, 1'b0, 10'd30);
    chk("wss", {1'b1, 14'h053c}, {wss_en, wss_data});
    vdi_host_i.wr(5'h12, 8'h01);
    vdi_host_i.wr(5'h13, 8'h80);
    vdi_host_i.wr(5'h14, 8'h02);
    vdi_host_i.wr(5'h15, 8'h00);
    lmask(1'b0, 1'b0, 10'd10, 1'b1, 1'b0);
    lmask(1'b0, 1'b0, 10'd9, 1'b0, 1'b0);
    lmask(1'b0, 1'b0, 10'd25, 1'b1, 1'b0);
    lmask(1'b0, 1'b1, 10'd11, 1'b1, 1'b0);
    lmask(1'b0, 1'b1, 10'd10, 1'b0, 1'b0);
    lmask(1'b1, 1'b0, 10'd7, 1'b0, 1'b1);
    lmask(1'b1, 1'b0, 10'd22, 1'b0, 1'b1);
    lmask(1'b1, 1'b0, 10'd6, 1'b0, 1'b0);
    lmask(1'b1, 1'b1, 10'd8, 1'b0, 1'b1);
    lmask(1'b1, 1'b1, 10'd7, 1'b0, 1'b0);
    ttx(8'h20, 10'd7, 3, 1037);
    ttx(8'h30, 10'd7, 4, 1037);
    ttx(8'h05, 10'd7, 1, 1032);
    ttx(8'hff, 10'd7, 16, 1007);
    ttx(8'h20, 10'd6, 40, 0);
    test_done;
  end

  initial begin
    #(50 * 20000);
    fails = fails + 1;
    test_done;
  end
endmodule // vdi_regs_tb
